// File: logic/short_opcode_first_byte_decoder.sv
// Behaviour
// - 01-03/05-07 store low/high accumulator byte
// - 08-0F load low/high accumulator byte
// - bits 1:0 pick other/static/frame/absolute
// - nibble 1 is AND low, OR high
// - nibble 2 is add low, subtract high
// - nibble 3 moves to address regs, compare
// - bit 2 picks own accumulator byte (address reg for 30-37), bits 1:0 = 00 give the opposite byte
// - nibble 4 bit clear/set, bits 2:0 bit
// - nibble 5 bit invert/test, bits 2:0 bit
// - 60-67 short jump, bits part distance
// - 68-6F conditional branches in fixed order
// - nibble 7 multiplies and general moves
// - 74-77, 7A-7E need second opcode byte
`timescale 1ns/10ps
`default_nettype none
module short_opcode_first_byte_decoder (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] opcode_i,
  output logic decode_valid_o,
  output short_opcode_pkg::decode_t decode_o
);

  // ----------------------------------------------------------------
  // Operand form helpers
  // ----------------------------------------------------------------
  // Memory or other-byte operand from bits 1:0
  function automatic short_opcode_pkg::form_t mem_form(input logic [1:0] mode,
                                                       input short_opcode_pkg::form_t other);
    short_opcode_pkg::form_t f;
    f = other;
    case (mode)
      short_opcode_pkg::MODE_STATIC: f = short_opcode_pkg::FORM_STATIC_DSP8;
      short_opcode_pkg::MODE_FRAME: f = short_opcode_pkg::FORM_FRAME_DSP8;
      short_opcode_pkg::MODE_ABS: f = short_opcode_pkg::FORM_ABSOLUTE;
      default: f = other;
    endcase
    return f;
  endfunction : mem_form

  // Bytes that a form adds after the opcode
  function automatic logic [1:0] form_bytes(input short_opcode_pkg::form_t f);
    logic [1:0] n;
    n = short_opcode_pkg::EXTRA_NONE;
    case (f)
      short_opcode_pkg::FORM_STATIC_DSP8: n = short_opcode_pkg::EXTRA_ONE;
      short_opcode_pkg::FORM_FRAME_DSP8: n = short_opcode_pkg::EXTRA_ONE;
      short_opcode_pkg::FORM_ABSOLUTE: n = short_opcode_pkg::EXTRA_TWO;
      default: n = short_opcode_pkg::EXTRA_NONE;
    endcase
    return n;
  endfunction : form_bytes

  // ----------------------------------------------------------------
  // Field selection
  // ----------------------------------------------------------------
  // Upper and lower nibble, own and opposite accumulator byte
  wire logic [3:0] hi = opcode_i[7:4];
  wire logic [3:0] lo = opcode_i[3:0];
  wire short_opcode_pkg::form_t own_acc = opcode_i[2] ? short_opcode_pkg::FORM_ACC_HIGH
                                                      : short_opcode_pkg::FORM_ACC_LOW;
  wire short_opcode_pkg::form_t other_acc = opcode_i[2] ? short_opcode_pkg::FORM_ACC_LOW
                                                        : short_opcode_pkg::FORM_ACC_HIGH;
  wire short_opcode_pkg::form_t sel_form = mem_form(opcode_i[1:0], other_acc);
  wire short_opcode_pkg::form_t addr_dst = opcode_i[2] ? short_opcode_pkg::FORM_ADDR_ONE
                                                       : short_opcode_pkg::FORM_ADDR_ZERO;

  // ----------------------------------------------------------------
  // First byte decode
  // ----------------------------------------------------------------
  short_opcode_pkg::decode_t next_decode;

  // Classify by upper nibble, then low code
  always_comb
  begin
    next_decode = '0;
    next_decode.index = opcode_i[2:0];
    next_decode.cond = short_opcode_pkg::cond_t'(opcode_i[2:0]);
    case (hi)
      short_opcode_pkg::NIB_MOVE:
      begin
        next_decode.op = short_opcode_pkg::OP_MOVE_S;
        if (opcode_i == short_opcode_pkg::OPC_BREAK)
        begin
          next_decode.op = short_opcode_pkg::OP_BREAK;
        end
        else if (opcode_i == short_opcode_pkg::OPC_IDLE)
        begin
          next_decode.op = short_opcode_pkg::OP_IDLE;
        end
        else if (!lo[3])
        begin
          next_decode.src = own_acc;
          next_decode.dst = sel_form;
        end
        else
        begin
          next_decode.src = sel_form;
          next_decode.dst = own_acc;
        end
      end
      short_opcode_pkg::NIB_LOGIC, short_opcode_pkg::NIB_ARITH:
      begin
        if (hi == short_opcode_pkg::NIB_LOGIC)
        begin
          next_decode.op = lo[3] ? short_opcode_pkg::OP_OR_S : short_opcode_pkg::OP_AND_S;
        end
        else
        begin
          next_decode.op = lo[3] ? short_opcode_pkg::OP_SUB_S : short_opcode_pkg::OP_ADD_S;
        end
        next_decode.src = sel_form;
        next_decode.dst = own_acc;
      end
      short_opcode_pkg::NIB_ADDR:
      begin
        next_decode.op = lo[3] ? short_opcode_pkg::OP_COMPARE_S : short_opcode_pkg::OP_MOVE_S;
        next_decode.src = sel_form;
        next_decode.dst = lo[3] ? own_acc : addr_dst;
      end
      short_opcode_pkg::NIB_BIT_CS, short_opcode_pkg::NIB_BIT_IT:
      begin
        if (hi == short_opcode_pkg::NIB_BIT_CS)
        begin
          next_decode.op = lo[3] ? short_opcode_pkg::OP_BIT_SET : short_opcode_pkg::OP_BIT_CLEAR;
        end
        else
        begin
          next_decode.op = lo[3] ? short_opcode_pkg::OP_BIT_TEST : short_opcode_pkg::OP_BIT_INVERT;
        end
        next_decode.dst = short_opcode_pkg::FORM_STATIC_DSP8;
      end
      short_opcode_pkg::NIB_JUMP:
      begin
        next_decode.op = lo[3] ? short_opcode_pkg::OP_BRANCH : short_opcode_pkg::OP_JUMP_S;
        next_decode.dst = short_opcode_pkg::FORM_LABEL;
      end
      short_opcode_pkg::NIB_MISC:
      begin
        next_decode.src = short_opcode_pkg::FORM_GENERAL;
        next_decode.dst = short_opcode_pkg::FORM_GENERAL;
        case (lo)
          short_opcode_pkg::LO_UMUL_BYTE: next_decode.op = short_opcode_pkg::OP_UMUL_BYTE;
          short_opcode_pkg::LO_UMUL_WORD: next_decode.op = short_opcode_pkg::OP_UMUL_WORD;
          short_opcode_pkg::LO_GMOVE_BYTE: next_decode.op = short_opcode_pkg::OP_GMOVE_BYTE;
          short_opcode_pkg::LO_GMOVE_WORD: next_decode.op = short_opcode_pkg::OP_GMOVE_WORD;
          short_opcode_pkg::LO_SMUL_BYTE: next_decode.op = short_opcode_pkg::OP_SMUL_BYTE;
          short_opcode_pkg::LO_SMUL_WORD: next_decode.op = short_opcode_pkg::OP_SMUL_WORD;
          short_opcode_pkg::LO_UNDEFINED: next_decode.op = short_opcode_pkg::OP_UNDEFINED;
          default: next_decode.op = short_opcode_pkg::OP_ESCAPE;
        endcase
        next_decode.word = (lo == short_opcode_pkg::LO_UMUL_WORD) || (lo == short_opcode_pkg::LO_GMOVE_WORD)
                           || (lo == short_opcode_pkg::LO_SMUL_WORD);
        if (lo == short_opcode_pkg::LO_UNDEFINED)
        begin
          next_decode.src = short_opcode_pkg::FORM_NONE;
          next_decode.dst = short_opcode_pkg::FORM_NONE;
        end
      end
      default:
      begin
        next_decode.op = short_opcode_pkg::OP_UPPER_HALF;
      end
    endcase
    // Byte count: label, general specifier and escape each take one byte
    if ((next_decode.dst == short_opcode_pkg::FORM_LABEL) || (next_decode.dst == short_opcode_pkg::FORM_GENERAL)
        || (next_decode.op == short_opcode_pkg::OP_ESCAPE))
    begin
      next_decode.extra_bytes = short_opcode_pkg::EXTRA_ONE;
    end
    else
    begin
      next_decode.extra_bytes = 2'(form_bytes(next_decode.src) + form_bytes(next_decode.dst));
    end
    next_decode.escape = (next_decode.op == short_opcode_pkg::OP_ESCAPE);
    next_decode.undefined = (next_decode.op == short_opcode_pkg::OP_UNDEFINED);
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Hold the decode of the last accepted byte
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      decode_valid_o <= 1'b0;
      decode_o <= '0;
    end
    else
    begin
      decode_valid_o <= byte_valid_i;
      if (byte_valid_i)
      begin
        decode_o <= next_decode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_break;
    byte_valid_i && opcode_i == short_opcode_pkg::OPC_BREAK |=> decode_valid_o
      && decode_o.op == short_opcode_pkg::OP_BREAK && decode_o.extra_bytes == short_opcode_pkg::EXTRA_NONE;
  endproperty
  a_break: assert property (p_break) else $error("break byte misdecoded");

  property p_idle;
    byte_valid_i && opcode_i == short_opcode_pkg::OPC_IDLE |=> decode_o.op == short_opcode_pkg::OP_IDLE
      && decode_o.src == short_opcode_pkg::FORM_NONE && decode_o.extra_bytes == short_opcode_pkg::EXTRA_NONE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle byte misdecoded");

  property p_store;
    byte_valid_i && hi == short_opcode_pkg::NIB_MOVE && !lo[3] && lo[1:0] != short_opcode_pkg::MODE_OTHER
      |=> decode_o.op == short_opcode_pkg::OP_MOVE_S && decode_o.src == ($past(opcode_i[2])
      ? short_opcode_pkg::FORM_ACC_HIGH : short_opcode_pkg::FORM_ACC_LOW);
  endproperty
  a_store: assert property (p_store) else $error("store source wrong");

  property p_load;
    byte_valid_i && hi == short_opcode_pkg::NIB_MOVE && lo[3] |=> decode_o.op == short_opcode_pkg::OP_MOVE_S
      && decode_o.dst == ($past(opcode_i[2]) ? short_opcode_pkg::FORM_ACC_HIGH : short_opcode_pkg::FORM_ACC_LOW);
  endproperty
  a_load: assert property (p_load) else $error("load destination wrong");

  property p_abs_count;
    byte_valid_i && opcode_i[7:6] == 2'h0 && opcode_i[1:0] == short_opcode_pkg::MODE_ABS
      |=> decode_o.extra_bytes == short_opcode_pkg::EXTRA_TWO;
  endproperty
  a_abs_count: assert property (p_abs_count) else $error("absolute address byte count wrong");

  property p_alu_dest;
    byte_valid_i && (hi == short_opcode_pkg::NIB_LOGIC || hi == short_opcode_pkg::NIB_ARITH)
      && opcode_i[1:0] == short_opcode_pkg::MODE_OTHER |=> decode_o.src != decode_o.dst
      && decode_o.dst == ($past(opcode_i[2]) ? short_opcode_pkg::FORM_ACC_HIGH : short_opcode_pkg::FORM_ACC_LOW);
  endproperty
  a_alu_dest: assert property (p_alu_dest) else $error("accumulator byte selection wrong");

  property p_logic;
    byte_valid_i && hi == short_opcode_pkg::NIB_LOGIC |=> decode_o.op == ($past(opcode_i[3])
      ? short_opcode_pkg::OP_OR_S : short_opcode_pkg::OP_AND_S);
  endproperty
  a_logic: assert property (p_logic) else $error("logic operation wrong");

  property p_arith;
    byte_valid_i && hi == short_opcode_pkg::NIB_ARITH |=> decode_o.op == ($past(opcode_i[3])
      ? short_opcode_pkg::OP_SUB_S : short_opcode_pkg::OP_ADD_S);
  endproperty
  a_arith: assert property (p_arith) else $error("arithmetic operation wrong");

  property p_addr_move;
    byte_valid_i && hi == short_opcode_pkg::NIB_ADDR && !lo[3] |=> decode_o.dst == ($past(opcode_i[2])
      ? short_opcode_pkg::FORM_ADDR_ONE : short_opcode_pkg::FORM_ADDR_ZERO);
  endproperty
  a_addr_move: assert property (p_addr_move) else $error("address register move wrong");

  property p_bit_index;
    byte_valid_i && (hi == short_opcode_pkg::NIB_BIT_CS || hi == short_opcode_pkg::NIB_BIT_IT)
      |=> decode_o.index == $past(opcode_i[2:0]) && decode_o.dst == short_opcode_pkg::FORM_STATIC_DSP8;
  endproperty
  a_bit_index: assert property (p_bit_index) else $error("bit number wrong");

  property p_branch;
    byte_valid_i && hi == short_opcode_pkg::NIB_JUMP && lo[3] |=> decode_o.op == short_opcode_pkg::OP_BRANCH
      && decode_o.cond == short_opcode_pkg::cond_t'($past(opcode_i[2:0]));
  endproperty
  a_branch: assert property (p_branch) else $error("branch condition wrong");

  property p_escape;
    byte_valid_i |=> decode_o.escape == ($past(hi) == short_opcode_pkg::NIB_MISC
      && ($past(lo[3:2]) == 2'h1 || ($past(lo) >= 4'ha && $past(lo) <= 4'he)));
  endproperty
  a_escape: assert property (p_escape) else $error("escape flag wrong");

  property p_undefined;
    byte_valid_i |=> decode_o.undefined == ($past(opcode_i) == short_opcode_pkg::OPC_UNDEFINED);
  endproperty
  a_undefined: assert property (p_undefined) else $error("undefined flag wrong");

endmodule : short_opcode_first_byte_decoder
`default_nettype wire

// File: logic/short_opcode_pkg.sv
`default_nettype none
package short_opcode_pkg;

  // ----------------------------------------------------------------
  // Opcode fields and special first bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_BREAK = 8'h00;
  localparam logic [7:0] OPC_IDLE = 8'h04;
  localparam logic [7:0] OPC_UNDEFINED = 8'h7f;
  localparam logic [3:0] NIB_MOVE = 4'h0;
  localparam logic [3:0] NIB_LOGIC = 4'h1;
  localparam logic [3:0] NIB_ARITH = 4'h2;
  localparam logic [3:0] NIB_ADDR = 4'h3;
  localparam logic [3:0] NIB_BIT_CS = 4'h4;
  localparam logic [3:0] NIB_BIT_IT = 4'h5;
  localparam logic [3:0] NIB_JUMP = 4'h6;
  localparam logic [3:0] NIB_MISC = 4'h7;
  localparam logic [1:0] MODE_OTHER = 2'h0;
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_FRAME = 2'h2;
  localparam logic [1:0] MODE_ABS = 2'h3;
  localparam logic [3:0] LO_UMUL_BYTE = 4'h0;
  localparam logic [3:0] LO_UMUL_WORD = 4'h1;
  localparam logic [3:0] LO_GMOVE_BYTE = 4'h2;
  localparam logic [3:0] LO_GMOVE_WORD = 4'h3;
  localparam logic [3:0] LO_SMUL_BYTE = 4'h8;
  localparam logic [3:0] LO_SMUL_WORD = 4'h9;
  localparam logic [3:0] LO_UNDEFINED = 4'hf;

  // ----------------------------------------------------------------
  // Count of operand bytes after the first byte
  // ----------------------------------------------------------------
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Decoded types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_BREAK = 5'h00, OP_IDLE = 5'h01, OP_MOVE_S = 5'h02, OP_AND_S = 5'h03,
    OP_OR_S = 5'h04, OP_ADD_S = 5'h05, OP_SUB_S = 5'h06, OP_COMPARE_S = 5'h07,
    OP_BIT_CLEAR = 5'h08, OP_BIT_SET = 5'h09, OP_BIT_INVERT = 5'h0a, OP_BIT_TEST = 5'h0b,
    OP_JUMP_S = 5'h0c, OP_BRANCH = 5'h0d, OP_UMUL_BYTE = 5'h0e, OP_UMUL_WORD = 5'h0f,
    OP_GMOVE_BYTE = 5'h10, OP_GMOVE_WORD = 5'h11, OP_SMUL_BYTE = 5'h12, OP_SMUL_WORD = 5'h13,
    OP_ESCAPE = 5'h14, OP_UNDEFINED = 5'h15, OP_UPPER_HALF = 5'h16
  } op_t;

  typedef enum logic [3:0] {
    FORM_NONE = 4'h0, FORM_ACC_LOW = 4'h1, FORM_ACC_HIGH = 4'h2, FORM_ADDR_ZERO = 4'h3,
    FORM_ADDR_ONE = 4'h4, FORM_STATIC_DSP8 = 4'h5, FORM_FRAME_DSP8 = 4'h6, FORM_ABSOLUTE = 4'h7,
    FORM_GENERAL = 4'h8, FORM_LABEL = 4'h9
  } form_t;

  typedef enum logic [2:0] {
    COND_UNSIGNED_GE = 3'h0, COND_UNSIGNED_GT = 3'h1, COND_EQUAL = 3'h2, COND_NEGATIVE = 3'h3,
    COND_UNSIGNED_LT = 3'h4, COND_UNSIGNED_LE = 3'h5, COND_NOT_EQUAL = 3'h6,
    COND_POSITIVE_OR_ZERO = 3'h7
  } cond_t;

  typedef struct packed {
    op_t op;
    logic word;
    form_t src;
    form_t dst;
    logic [2:0] index;
    cond_t cond;
    logic [1:0] extra_bytes;
    logic escape;
    logic undefined;
  } decode_t;

endpackage : short_opcode_pkg
`default_nettype wire

// File: verif/opcode_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Fetch stage model feeding first opcode bytes
// ------------------------------------------------------------------
module opcode_fetch_model (
  input wire logic clk_i,
  output logic byte_valid_o,
  output logic [7:0] opcode_o
);
  // Idle bus at time zero
  initial
  begin
    byte_valid_o = 1'b0;
    opcode_o = 8'h00;
  end

  // Present one byte for one cycle, changed just after the rising edge
  task automatic present(input logic [7:0] value);
    @(posedge clk_i);
    #1;
    byte_valid_o = 1'b1;
    opcode_o = value;
  endtask : present

  // No byte this cycle; the byte lines show the inverse of the last value
  task automatic idle();
    @(posedge clk_i);
    #1;
    byte_valid_o = 1'b0;
    opcode_o = ~opcode_o;
  endtask : idle
endmodule : opcode_fetch_model
`default_nettype wire

// File: verif/test_short_opcode_first_byte_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Compare two values and count the outcome
`define CHECK_EQ(name, exp, got) \
  begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", name, exp, got); end end
module test_short_opcode_first_byte_decoder;
  // ------------------------------------------------------------------
  // Signals, clock and instances
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opc;
    short_opcode_pkg::op_t op;
    short_opcode_pkg::form_t src;
    short_opcode_pkg::form_t dst;
    logic [1:0] extra;
    logic [1:0] fchk;
  } row_t;
  localparam short_opcode_pkg::form_t none_f = short_opcode_pkg::FORM_NONE;
  localparam short_opcode_pkg::form_t acc_lo = short_opcode_pkg::FORM_ACC_LOW;
  localparam short_opcode_pkg::form_t acc_hi = short_opcode_pkg::FORM_ACC_HIGH;
  localparam short_opcode_pkg::form_t adr_zero = short_opcode_pkg::FORM_ADDR_ZERO;
  localparam short_opcode_pkg::form_t adr_one = short_opcode_pkg::FORM_ADDR_ONE;
  localparam short_opcode_pkg::form_t sbd = short_opcode_pkg::FORM_STATIC_DSP8;
  localparam short_opcode_pkg::form_t fbd = short_opcode_pkg::FORM_FRAME_DSP8;
  localparam short_opcode_pkg::form_t absw = short_opcode_pkg::FORM_ABSOLUTE;
  localparam short_opcode_pkg::form_t gen_f = short_opcode_pkg::FORM_GENERAL;
  localparam short_opcode_pkg::form_t label_f = short_opcode_pkg::FORM_LABEL;
  logic clk = 1'b0;
  logic arst_n;
  logic byte_valid;
  logic [7:0] opcode;
  logic decode_valid;
  short_opcode_pkg::decode_t decode;
  int mismatches = 0;
  int checks = 0;
  // Opcode, operation, source, destination, extra bytes, form check mask
  row_t rows [32] = '{
    '{8'h00, short_opcode_pkg::OP_BREAK, none_f, none_f, 2'h0, 2'h3},
    '{8'h04, short_opcode_pkg::OP_IDLE, none_f, none_f, 2'h0, 2'h3},
    '{8'h01, short_opcode_pkg::OP_MOVE_S, acc_lo, sbd, 2'h1, 2'h3},
    '{8'h03, short_opcode_pkg::OP_MOVE_S, acc_lo, absw, 2'h2, 2'h3},
    '{8'h06, short_opcode_pkg::OP_MOVE_S, acc_hi, fbd, 2'h1, 2'h3},
    '{8'h08, short_opcode_pkg::OP_MOVE_S, acc_hi, acc_lo, 2'h0, 2'h3},
    '{8'h0c, short_opcode_pkg::OP_MOVE_S, acc_lo, acc_hi, 2'h0, 2'h3},
    '{8'h0f, short_opcode_pkg::OP_MOVE_S, absw, acc_hi, 2'h2, 2'h3},
    '{8'h11, short_opcode_pkg::OP_AND_S, sbd, acc_lo, 2'h1, 2'h3},
    '{8'h1c, short_opcode_pkg::OP_OR_S, acc_lo, acc_hi, 2'h0, 2'h3},
    '{8'h22, short_opcode_pkg::OP_ADD_S, fbd, acc_lo, 2'h1, 2'h3},
    '{8'h2b, short_opcode_pkg::OP_SUB_S, absw, acc_lo, 2'h2, 2'h3},
    '{8'h30, short_opcode_pkg::OP_MOVE_S, acc_hi, adr_zero, 2'h0, 2'h3},
    '{8'h37, short_opcode_pkg::OP_MOVE_S, absw, adr_one, 2'h2, 2'h3},
    '{8'h3d, short_opcode_pkg::OP_COMPARE_S, sbd, acc_hi, 2'h1, 2'h3},
    '{8'h43, short_opcode_pkg::OP_BIT_CLEAR, none_f, sbd, 2'h1, 2'h3},
    '{8'h4f, short_opcode_pkg::OP_BIT_SET, none_f, sbd, 2'h1, 2'h3},
    '{8'h50, short_opcode_pkg::OP_BIT_INVERT, none_f, sbd, 2'h1, 2'h3},
    '{8'h5a, short_opcode_pkg::OP_BIT_TEST, none_f, sbd, 2'h1, 2'h3},
    '{8'h65, short_opcode_pkg::OP_JUMP_S, none_f, label_f, 2'h1, 2'h3},
    '{8'h70, short_opcode_pkg::OP_UMUL_BYTE, gen_f, gen_f, 2'h1, 2'h3},
    '{8'h71, short_opcode_pkg::OP_UMUL_WORD, gen_f, gen_f, 2'h1, 2'h3},
    '{8'h72, short_opcode_pkg::OP_GMOVE_BYTE, gen_f, gen_f, 2'h1, 2'h3},
    '{8'h73, short_opcode_pkg::OP_GMOVE_WORD, gen_f, gen_f, 2'h1, 2'h3},
    '{8'h78, short_opcode_pkg::OP_SMUL_BYTE, gen_f, gen_f, 2'h1, 2'h3},
    '{8'h79, short_opcode_pkg::OP_SMUL_WORD, gen_f, gen_f, 2'h1, 2'h3},
    '{8'h74, short_opcode_pkg::OP_ESCAPE, none_f, none_f, 2'h1, 2'h0},
    '{8'h77, short_opcode_pkg::OP_ESCAPE, none_f, none_f, 2'h1, 2'h0},
    '{8'h7a, short_opcode_pkg::OP_ESCAPE, none_f, none_f, 2'h1, 2'h0},
    '{8'h7e, short_opcode_pkg::OP_ESCAPE, none_f, none_f, 2'h1, 2'h0},
    '{8'h7f, short_opcode_pkg::OP_UNDEFINED, none_f, none_f, 2'h0, 2'h3},
    '{8'h9c, short_opcode_pkg::OP_UPPER_HALF, none_f, none_f, 2'h0, 2'h3}
  };
  short_opcode_pkg::cond_t conds [8] = '{short_opcode_pkg::COND_UNSIGNED_GE, short_opcode_pkg::COND_UNSIGNED_GT,
    short_opcode_pkg::COND_EQUAL, short_opcode_pkg::COND_NEGATIVE, short_opcode_pkg::COND_UNSIGNED_LT,
    short_opcode_pkg::COND_UNSIGNED_LE, short_opcode_pkg::COND_NOT_EQUAL, short_opcode_pkg::COND_POSITIVE_OR_ZERO};

  // Core clock, 4 ns period
  always #2 clk = ~clk;

  opcode_fetch_model u_fetch (
    .clk_i(clk),
    .byte_valid_o(byte_valid),
    .opcode_o(opcode)
  );

  short_opcode_first_byte_decoder u_dut (
    .clk_i(clk),
    .arst_n_i(arst_n),
    .byte_valid_i(byte_valid),
    .opcode_i(opcode),
    .decode_valid_o(decode_valid),
    .decode_o(decode)
  );

  // ------------------------------------------------------------------
  // Checking and closing tasks
  // ------------------------------------------------------------------
  // Compare the held decode against one row
  task automatic check_row(input row_t r, input logic v);
    logic esc;
    logic wrd;
    esc = (r.opc >= 8'h74 && r.opc <= 8'h77) || (r.opc >= 8'h7a && r.opc <= 8'h7e);
    wrd = (r.opc == 8'h71) || (r.opc == 8'h73) || (r.opc == 8'h79);
    `CHECK_EQ("valid", v, decode_valid)
    `CHECK_EQ("op", r.op, decode.op)
    `CHECK_EQ("extra", r.extra, decode.extra_bytes)
    `CHECK_EQ("escape", esc, decode.escape)
    `CHECK_EQ("undefined", r.opc == 8'h7f, decode.undefined)
    `CHECK_EQ("index", r.opc[2:0], decode.index)
    `CHECK_EQ("word", wrd, decode.word)
    if (r.fchk[0])
      `CHECK_EQ("dst", r.dst, decode.dst)
    if (r.fchk[1])
      `CHECK_EQ("src", r.src, decode.src)
  endtask : check_row

  // Print the verdict and stop
  task automatic end_sim();
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  // Reset, table of ordinary bytes back to back, then awkward cases
  initial
  begin
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    `CHECK_EQ("reset valid", 1'b0, decode_valid)
    `CHECK_EQ("reset decode", short_opcode_pkg::decode_t'(0), decode)
    for (int i = 0; i < 32; i++)
    begin
      u_fetch.present(rows[i].opc);
      if (i > 0)
        check_row(rows[i - 1], 1'b1);
    end
    u_fetch.idle();
    check_row(rows[31], 1'b1);
    u_fetch.idle();
    check_row(rows[31], 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      if (i < 8)
        u_fetch.present(8'h68 + 8'(i));
      else
        u_fetch.idle();
      if (i > 0)
      begin
        `CHECK_EQ("branch op", short_opcode_pkg::OP_BRANCH, decode.op)
        `CHECK_EQ("branch cond", conds[i - 1], decode.cond)
        `CHECK_EQ("branch dst", short_opcode_pkg::FORM_LABEL, decode.dst)
        `CHECK_EQ("branch extra", 2'h1, decode.extra_bytes)
      end
    end
    u_fetch.present(8'h3d);
    u_fetch.idle();
    check_row(rows[14], 1'b1);
    arst_n = 1'b0;
    #1;
    `CHECK_EQ("mid reset valid", 1'b0, decode_valid)
    `CHECK_EQ("mid reset decode", short_opcode_pkg::decode_t'(0), decode)
    u_fetch.idle();
    arst_n = 1'b1;
    u_fetch.idle();
    `CHECK_EQ("after reset decode", short_opcode_pkg::decode_t'(0), decode)
    u_fetch.present(8'h00);
    u_fetch.idle();
    check_row(rows[0], 1'b1);
    end_sim();
  end

  // Guard against a hung run
  initial
  begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule : test_short_opcode_first_byte_decoder
`default_nettype wire
